// ### bench/node_phy_regs_tb.sv
`timescale 1ns/1ps
module node_phy_regs_tb;
   logic                           clk;
   logic                           nrst;
   logic                           psel;
   logic                           penable;
   logic                           pwrite;
   logic [7:0]                     paddr;
   logic [31:0]                    pwdata;
   logic [31:0]                    prdata;
   logic                           pready;
   logic                           pslverr;
   node_phy_pkg::phy_status_type   status;
   node_phy_pkg::phy_transfer_type xfer;
   node_phy_pkg::phy_request_type  req;
   logic                           req_ready;
   logic [15:0]                    node_id;
   logic [3:0]                     phy_delay;
   int                             accepted;
   int                             checks;
   int                             mismatches;
   logic [31:0]                    rd;
   logic                           err;

   always #50 clk = ~clk;

   node_phy_regs dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phy_status(status), .phy_xfer(xfer), .phy_req(req),
      .phy_req_ready(req_ready), .node_id(node_id));

   phy_model phy_u (.clk(clk), .nrst(nrst), .phy_req(req), .phy_req_ready(req_ready),
      .phy_xfer(xfer), .delay(phy_delay), .accepted(accepted));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      @(posedge clk);
   endtask

   task automatic poll(input logic [31:0] mask, input logic [31:0] want);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'hec, 32'h0000_0000);
         n++;
      end while ((rd & mask) !== want && n < 40);
      if ((rd & mask) !== want) begin
         mismatches++;
         end_sim();
      end
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      clk        = 1'b0;
      nrst       = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0000_0000;
      status     = '0;
      phy_delay  = 4'h5;
      checks     = 0;
      mismatches = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h0000_ffff);
      chk({31'h0, err}, 32'h0000_0000);
      chk({16'h0000, node_id}, 32'h0000_ffff);
      apb(1'b0, 8'hec, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset done");
      apb(1'b1, 8'he8, 32'hffff_ffff);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h0000_ffff);
      apb(1'b1, 8'he8, 32'h0000_5540);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h0000_557f);
      chk({16'h0000, node_id}, 32'h0000_557f);
      $display("test bus number done");
      status <= '{1'b0, 1'b1, 6'h2a, 1'b1, 1'b1};
      @(posedge clk);
      status.self_id_done <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'hc800_556a);
      chk({16'h0000, node_id}, 32'h0000_556a);
      apb(1'b1, 8'he8, 32'h37ff_557f);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'hc800_556a);
      status <= '{1'b1, 1'b0, 6'h2a, 1'b0, 1'b0};
      @(posedge clk);
      status.bus_reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h4000_556a);
      // self id done with node number 63, root and cable power both clear
      status <= '{1'b0, 1'b1, 6'h3f, 1'b0, 1'b0};
      @(posedge clk);
      status.self_id_done <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h8000_557f);
      $display("test self id done");
      apb(1'b1, 8'hec, 32'h0000_43a5);
      apb(1'b0, 8'hec, 32'h0000_0000);
      chk(rd & 32'h0000_4000, 32'h0000_4000);
      poll(32'h0000_4000, 32'h0000_0000);
      chk(accepted, 1);
      chk({24'h00_0000, phy_u.regs[3]}, 32'h0000_00a5);
      $display("test phy write done");
      apb(1'b1, 8'hec, 32'h0000_8300);
      poll(32'h8000_8000, 32'h8000_0000);
      chk(rd, 32'h83a5_0300);
      apb(1'b1, 8'hec, 32'hffff_3fff);
      apb(1'b0, 8'hec, 32'h0000_0000);
      chk(rd, 32'h83a5_0fff);
      phy_delay <= 4'h0;
      apb(1'b1, 8'hec, 32'h0000_8200);
      apb(1'b0, 8'hec, 32'h0000_0000);
      chk(rd & 32'h8000_8000, 32'h0000_8000);
      poll(32'h8000_8000, 32'h8000_0000);
      chk(rd, 32'h8252_0200);
      chk(accepted, 3);
      $display("test phy read done");
      apb(1'b1, 8'hf0, 32'hffff_ffff);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b0, 8'hf0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'he8, 32'h0000_0000);
      chk(rd, 32'h8000_557f);
      $display("test unmapped done");
      end_sim();
   end
endmodule // node_phy_regs_tb

// ### bench/phy_model.sv
`timescale 1ns/1ps
module phy_model (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           nrst,
   // link side
   input  wire node_phy_pkg::phy_request_type  phy_req,
   output logic                                phy_req_ready,
   output node_phy_pkg::phy_transfer_type      phy_xfer,
   // test control
   input  wire logic [3:0]                     delay,
   output int                                  accepted
);
   logic [7:0] regs [16];
   logic [3:0] wait_q;

   // ----------------------------------------------------------------
   // request service
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phy_req_ready <= 1'b0;
         phy_xfer      <= '0;
         wait_q        <= 4'h0;
         accepted      <= 0;
         for (int i = 0; i < 16; i++) begin
            regs[i] <= {4'h5, i[3:0]};
         end
      end else begin
         // idle transfer lines toggle, never hold stale data
         phy_xfer.valid <= 1'b0;
         phy_xfer.addr  <= ~phy_xfer.addr;
         phy_xfer.data  <= ~phy_xfer.data;
         if (phy_req.valid && phy_req_ready) begin
            phy_req_ready <= 1'b0;
            wait_q        <= 4'h0;
            accepted      <= accepted + 1;
            if (phy_req.write) begin
               regs[phy_req.addr] <= phy_req.data;
            end else begin
               phy_xfer <= '{1'b1, phy_req.addr, regs[phy_req.addr]};
            end
         end else if (phy_req.valid) begin
            if (wait_q == delay) begin
               phy_req_ready <= 1'b1;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule // phy_model

// ### rtl/node_phy_pkg.sv
// Functional notes
// - node id is the bus number in 15..6 joined to the node number in 5..0
// - id valid flag clears on bus reset and sets when a new node number arrives
// - root flag loads at self id done from the phy report of whether it is root
// - cable power flag in bit 27 follows the phy cable power good report
// - bus number field is software writable and resets to all ones
// - node number loads from the phy after self id; software cannot write it
// - node identity bits 29..28 and 26..16 read as zero
// - read done clears when software sets the read or write request bit
// - read done sets when a register transfer arrives from the phy
// - address of each received phy register transfer lands in bits 27..24
// - returned phy register contents land in bits 23..16
// - software sets bit 15 for a read; hardware clears it once sent
// - software sets bit 14 for a write; hardware clears it once sent
// - bits 11..8 give the phy register address to read or write
// - bits 7..0 are sent as write data for writes and ignored for reads
// - phy access bits 30..28 and 13..12 read as zero
package node_phy_pkg;

   // ----------------------------------------------------------------
   // bus and map
   // ----------------------------------------------------------------
   localparam int              ADDR_W            = 8;
   localparam int              DATA_W            = 32;
   localparam logic [7:0]      NODE_ID_OFFSET    = 8'he8;
   localparam logic [7:0]      PHY_ACCESS_OFFSET = 8'hec;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ID_VALID_BIT = 31;
   localparam int ROOT_BIT     = 30;
   localparam int CPS_BIT      = 27;
   localparam int BUS_HI       = 15;
   localparam int BUS_LO       = 6;
   localparam int NODE_HI      = 5;
   localparam int NODE_LO      = 0;
   localparam int RD_DONE_BIT  = 31;
   localparam int RET_ADDR_HI  = 27;
   localparam int RET_ADDR_LO  = 24;
   localparam int RET_VAL_HI   = 23;
   localparam int RET_VAL_LO   = 16;
   localparam int RD_REQ_BIT   = 15;
   localparam int WR_REQ_BIT   = 14;
   localparam int TGT_HI       = 11;
   localparam int TGT_LO       = 8;
   localparam int WRV_HI       = 7;
   localparam int WRV_LO       = 0;

   localparam logic [31:0] NODE_RSVD_MASK = 32'h37ff_0000;
   localparam logic [31:0] PHY_RSVD_MASK  = 32'h7000_3000;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [9:0] BUS_NUMBER_RESET  = 10'h3ff;
   localparam logic [5:0] NODE_NUMBER_RESET = 6'h3f;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SEL_NONE, SEL_NODE, SEL_PHY} reg_sel_type;
   typedef enum logic {REQ_IDLE, REQ_WAIT} req_state_type;

   typedef struct packed {
      logic       bus_reset;
      logic       self_id_done;
      logic [5:0] node_number;
      logic       is_root;
      logic       cable_power_good;
   } phy_status_type;

   typedef struct packed {
      logic       valid;
      logic [3:0] addr;
      logic [7:0] data;
   } phy_transfer_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [3:0] addr;
      logic [7:0] data;
   } phy_request_type;

   typedef struct packed {
      logic [9:0]       bus_number_a;
      logic [5:0]       physical_node_number;
      logic             id_valid_flag;
      logic             root;
      logic             cable_power_good;
      logic             phy_read_done;
      logic [3:0]       phy_returned_address;
      logic [7:0]       phy_returned_value;
      logic             phy_read_request;
      logic             phy_write_request;
      logic [3:0]       phy_target_address;
      logic [7:0]       phy_write_value;
      req_state_type    req_state;
      phy_request_type  req;
      logic [31:0]      rdata;
   } state_type;

endpackage

// ### rtl/node_phy_regs.sv
`timescale 1ns/1ps
module node_phy_regs (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          nrst,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [node_phy_pkg::ADDR_W-1:0] paddr,
   input  wire logic [node_phy_pkg::DATA_W-1:0] pwdata,
   output logic      [node_phy_pkg::DATA_W-1:0] prdata,
   output logic                               pready,
   output logic                               pslverr,
   // phy side
   input  wire node_phy_pkg::phy_status_type   phy_status,
   input  wire node_phy_pkg::phy_transfer_type phy_xfer,
   output node_phy_pkg::phy_request_type       phy_req,
   input  wire logic                          phy_req_ready,
   // node identity
   output logic      [15:0]                   node_id
);

   // ----------------------------------------------------------------
   // decode and read words
   // ----------------------------------------------------------------
   function automatic node_phy_pkg::reg_sel_type decode(
      input logic [node_phy_pkg::ADDR_W-1:0] a);
      if (a == node_phy_pkg::NODE_ID_OFFSET)
         return node_phy_pkg::SEL_NODE;
      else if (a == node_phy_pkg::PHY_ACCESS_OFFSET)
         return node_phy_pkg::SEL_PHY;
      else
         return node_phy_pkg::SEL_NONE;
   endfunction

   function automatic logic [31:0] read_word(
      input node_phy_pkg::reg_sel_type s,
      input node_phy_pkg::state_type   st);
      logic [31:0] w;
      w = '0;
      unique case (s)
         node_phy_pkg::SEL_NODE: begin
            w[node_phy_pkg::ID_VALID_BIT] = st.id_valid_flag;
            w[node_phy_pkg::ROOT_BIT]     = st.root;
            w[node_phy_pkg::CPS_BIT]      = st.cable_power_good;
            w[node_phy_pkg::BUS_HI:node_phy_pkg::BUS_LO]   = st.bus_number_a;
            w[node_phy_pkg::NODE_HI:node_phy_pkg::NODE_LO] = st.physical_node_number;
         end
         node_phy_pkg::SEL_PHY: begin
            w[node_phy_pkg::RD_DONE_BIT] = st.phy_read_done;
            w[node_phy_pkg::RET_ADDR_HI:node_phy_pkg::RET_ADDR_LO] = st.phy_returned_address;
            w[node_phy_pkg::RET_VAL_HI:node_phy_pkg::RET_VAL_LO]   = st.phy_returned_value;
            w[node_phy_pkg::RD_REQ_BIT]  = st.phy_read_request;
            w[node_phy_pkg::WR_REQ_BIT]  = st.phy_write_request;
            w[node_phy_pkg::TGT_HI:node_phy_pkg::TGT_LO] = st.phy_target_address;
            w[node_phy_pkg::WRV_HI:node_phy_pkg::WRV_LO] = st.phy_write_value;
         end
         node_phy_pkg::SEL_NONE: begin
            w = '0;
         end
      endcase
      return w;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   node_phy_pkg::state_type     q;
   node_phy_pkg::state_type     d;
   node_phy_pkg::reg_sel_type   sel;
   logic                        setup;
   logic                        access;
   logic                        wr_access;
   logic                        req_set;

   assign sel       = decode(paddr);
   assign setup     = psel & ~penable;
   assign access    = psel & penable;
   assign wr_access = access & pwrite;
   assign req_set   = wr_access && (sel == node_phy_pkg::SEL_PHY) &&
                      (pwdata[node_phy_pkg::RD_REQ_BIT] | pwdata[node_phy_pkg::WR_REQ_BIT]);

   assign pready  = access;
   assign pslverr = access && (sel == node_phy_pkg::SEL_NONE);
   assign prdata  = q.rdata;
   assign phy_req = q.req;
   assign node_id = {q.bus_number_a, q.physical_node_number};

   always_comb begin
      d = q;
      d.cable_power_good = phy_status.cable_power_good;
      if (phy_status.bus_reset) begin
         d.id_valid_flag = 1'b0;
      end
      if (phy_status.self_id_done) begin
         d.physical_node_number = phy_status.node_number;
         d.id_valid_flag        = 1'b1;
         d.root                 = phy_status.is_root;
      end

      // request engine to the phy
      unique case (q.req_state)
         node_phy_pkg::REQ_IDLE: begin
            if (q.phy_read_request | q.phy_write_request) begin
               d.req.valid = 1'b1;
               // write served first if both set
               d.req.write = q.phy_write_request;
               d.req.addr  = q.phy_target_address;
               d.req.data  = q.phy_write_request ? q.phy_write_value : '0;
               d.req_state = node_phy_pkg::REQ_WAIT;
            end
         end
         node_phy_pkg::REQ_WAIT: begin
            if (phy_req_ready) begin
               d.req.valid = 1'b0;
               d.req_state = node_phy_pkg::REQ_IDLE;
               if (q.req.write) begin
                  d.phy_write_request = 1'b0;
               end else begin
                  d.phy_read_request = 1'b0;
               end
            end
         end
      endcase

      // register writes
      if (wr_access) begin
         unique case (sel)
            node_phy_pkg::SEL_NODE: begin
               d.bus_number_a = pwdata[node_phy_pkg::BUS_HI:node_phy_pkg::BUS_LO];
            end
            node_phy_pkg::SEL_PHY: begin
               d.phy_target_address = pwdata[node_phy_pkg::TGT_HI:node_phy_pkg::TGT_LO];
               d.phy_write_value    = pwdata[node_phy_pkg::WRV_HI:node_phy_pkg::WRV_LO];
               if (pwdata[node_phy_pkg::RD_REQ_BIT]) begin
                  d.phy_read_request = 1'b1;
               end
               if (pwdata[node_phy_pkg::WR_REQ_BIT]) begin
                  d.phy_write_request = 1'b1;
               end
            end
            node_phy_pkg::SEL_NONE: begin
               d.bus_number_a = q.bus_number_a;
            end
         endcase
      end
      if (req_set) begin
         d.phy_read_done = 1'b0;
      end
      if (phy_xfer.valid) begin
         d.phy_read_done        = 1'b1;
         d.phy_returned_address = phy_xfer.addr;
         d.phy_returned_value   = phy_xfer.data;
      end

      // read word with zero reserved bits
      if (setup) begin
         d.rdata = read_word(sel, q);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q                      <= '0;
         q.bus_number_a         <= node_phy_pkg::BUS_NUMBER_RESET;
         q.physical_node_number <= node_phy_pkg::NODE_NUMBER_RESET;
         q.req_state            <= node_phy_pkg::REQ_IDLE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_pending;
      q.req_state == node_phy_pkg::REQ_IDLE && (q.phy_read_request || q.phy_write_request);
   endsequence

   sequence s_sent;
      q.req.valid && phy_req_ready;
   endsequence

   a_node_id_form: assert property (
      wr_access && sel == node_phy_pkg::SEL_NODE && !phy_status.self_id_done |=>
      node_id == {$past(pwdata[node_phy_pkg::BUS_HI:node_phy_pkg::BUS_LO]),
                  $past(q.physical_node_number)})
      else $error("node id not formed from bus and node number");

   a_id_valid_clear: assert property (
      phy_status.bus_reset && !phy_status.self_id_done |=> !q.id_valid_flag)
      else $error("id valid not cleared by bus reset");

   a_node_load: assert property (
      phy_status.self_id_done |=> q.id_valid_flag &&
      q.physical_node_number == $past(phy_status.node_number) && q.root == $past(phy_status.is_root))
      else $error("node number or root not loaded");

   a_node_read_only: assert property (
      !phy_status.self_id_done |=> $stable(q.physical_node_number))
      else $error("node number changed without self id");

   a_cps_follow: assert property (
      ##1 q.cable_power_good == $past(phy_status.cable_power_good))
      else $error("cable power flag does not follow phy");

   a_bus_write: assert property (
      wr_access && sel == node_phy_pkg::SEL_NODE |=>
      q.bus_number_a == $past(pwdata[node_phy_pkg::BUS_HI:node_phy_pkg::BUS_LO]))
      else $error("bus number write lost");

   a_done_clear: assert property (
      req_set && !phy_xfer.valid |=> !q.phy_read_done)
      else $error("read done not cleared by request");

   a_done_set: assert property (
      phy_xfer.valid |=> q.phy_read_done && q.phy_returned_address == $past(phy_xfer.addr)
      && q.phy_returned_value == $past(phy_xfer.data))
      else $error("phy transfer not captured");

   a_req_issue: assert property (
      s_pending |=> q.req.valid && q.req.addr == $past(q.phy_target_address) &&
      q.req.data == ($past(q.phy_write_request) ? $past(q.phy_write_value) : 8'h00))
      else $error("phy request not issued correctly");

   a_req_clear: assert property (
      s_sent ##0 !req_set |=> !q.req.valid &&
      ($past(q.req.write) ? !q.phy_write_request : !q.phy_read_request))
      else $error("request bit not cleared after send");

   a_reserved_zero: assert property (
      access && sel == node_phy_pkg::SEL_NODE |-> (prdata & node_phy_pkg::NODE_RSVD_MASK) == '0)
      else $error("node identity reserved bits not zero");

   a_phy_rsvd_zero: assert property (
      access && sel == node_phy_pkg::SEL_PHY |-> (prdata & node_phy_pkg::PHY_RSVD_MASK) == '0)
      else $error("phy access reserved bits not zero");

   a_req_hold: assert property (
      q.req.valid && !phy_req_ready |=> q.req.valid && $stable(q.req))
      else $error("phy request changed before acceptance");

   a_read_data_zero: assert property (
      q.req.valid && !q.req.write |-> q.req.data == '0)
      else $error("read request carries write data");

   a_req_bits_set: assert property (
      req_set |=> (q.phy_read_request || !$past(pwdata[node_phy_pkg::RD_REQ_BIT])) &&
      (q.phy_write_request || !$past(pwdata[node_phy_pkg::WR_REQ_BIT])))
      else $error("request bit not set by software write");

   a_target_write: assert property (
      wr_access && sel == node_phy_pkg::SEL_PHY |=>
      q.phy_target_address == $past(pwdata[node_phy_pkg::TGT_HI:node_phy_pkg::TGT_LO]) &&
      q.phy_write_value == $past(pwdata[node_phy_pkg::WRV_HI:node_phy_pkg::WRV_LO]))
      else $error("phy target address or write value lost");

   a_unmapped_ignore: assert property (
      wr_access && sel == node_phy_pkg::SEL_NONE |=> $stable(q.bus_number_a) &&
      $stable(q.phy_target_address) && $stable(q.phy_write_value))
      else $error("unmapped write changed a register");

   a_root_hold: assert property (
      !phy_status.self_id_done |=> $stable(q.root))
      else $error("root flag changed without self id");

   a_done_hold: assert property (
      !req_set && !phy_xfer.valid |=> $stable(q.phy_read_done))
      else $error("read done changed without cause");

endmodule // node_phy_regs
